// >>> logic/otpg_pkg.sv
package otpg_pkg;
  localparam int          CODE_W      = 10;
  localparam int          CNT_W       = 16;
  localparam int          START_OFFS  = 6;
  localparam logic [9:0]  CODE_MAX    = 10'h3FF;
  localparam logic [9:0]  BASE_RST    = 10'h000;
  localparam logic [9:0]  PITCH_RST   = 10'h001;
  localparam logic [9:0]  STEP_RST    = 10'h001;
  localparam logic [15:0] WIN_ST_RST  = 16'h0000;
  localparam logic [15:0] WIN_WID_RST = 16'h0000;
  localparam logic [7:0]  LDLY_RST    = 8'h00;
  localparam logic [1:0]  KIND_FIXED  = 2'h0;
  localparam logic [1:0]  KIND_HORIZ  = 2'h1;
  localparam logic [1:0]  KIND_VERT   = 2'h2;
  localparam logic [1:0]  KIND_LATT   = 2'h3;
  localparam logic [1:0]  SEL_ALL     = 2'h0;
  localparam logic [1:0]  SEL_RED     = 2'h1;
  localparam logic [1:0]  SEL_GREEN   = 2'h2;
  localparam logic [1:0]  SEL_BLUE    = 2'h3;
  // register offsets (byte addresses, one word each)
  localparam logic [5:0]  OFS_CTRL    = 6'h00;
  localparam logic [5:0]  OFS_BASE    = 6'h04;
  localparam logic [5:0]  OFS_PITCH   = 6'h08;
  localparam logic [5:0]  OFS_STEP    = 6'h0C;
  localparam logic [5:0]  OFS_WIN_ST  = 6'h10;
  localparam logic [5:0]  OFS_WIN_WID = 6'h14;
  localparam logic [5:0]  OFS_LDLY    = 6'h18;
  localparam logic [5:0]  OFS_STATUS  = 6'h1C;
  // ctrl field positions
  localparam int          CTRL_EN_BIT = 0;
  localparam int          CTRL_KIND_LO = 4;
  localparam int          CTRL_SEL_LO = 8;
endpackage

// >>> logic/otpg_ramp.sv
`timescale 1ns/1ns
// one ramp channel: a code that starts at base, adds step per pitch tick, wraps past max
module otpg_ramp
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       clear_in,
  input  wire logic       tick_in,
  input  wire logic [9:0] base_in,
  input  wire logic [9:0] step_in,
  output logic      [9:0] code_out
);
  typedef struct packed {
    logic [9:0] code;
  } otpg_ramp_s;

  otpg_ramp_s st_r;
  otpg_ramp_s st_nxt;
  logic [10:0] sum;

  always_comb
  begin
    st_nxt = st_r;
    sum    = {1'b0, st_r.code} + {1'b0, step_in};
    if (clear_in)
      st_nxt.code = base_in;
    else if (tick_in)
    begin
      // overflow beyond the 10-bit range restarts the ramp at base
      if (sum > {1'b0, otpg_pkg::CODE_MAX})
        st_nxt.code = base_in;
      else
        st_nxt.code = sum[9:0];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      st_r <= '{code: otpg_pkg::BASE_RST};
    else
      st_r <= st_nxt;
  end

  assign code_out = st_r.code;

  ramp_wrap_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!clear_in && tick_in && ({1'b0, code_out} + {1'b0, step_in}) > 11'h3FF) |=> code_out == $past(base_in))
    else $error("ramp did not wrap to base");
endmodule // otpg_ramp

// >>> logic/otpg_top.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module otpg_top
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // pixel stream
  input  wire logic        line_clamp_input_in,
  input  wire logic [9:0]  conv_red_in,
  input  wire logic [9:0]  conv_green_in,
  input  wire logic [9:0]  conv_blue_in,
  output logic      [9:0]  pix_red_out,
  output logic      [9:0]  pix_green_out,
  output logic      [9:0]  pix_blue_out,
  output logic             pix_valid_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OTPG_BUS_IDLE = 2'b00,
    OTPG_BUS_ACK  = 2'b01
  } otpg_bus_e;

  typedef struct packed {
    otpg_bus_e   bus;
    logic [31:0] rdata;
    logic        en;
    logic [1:0]  kind;
    logic [1:0]  sel;
    logic [9:0]  base;
    logic [9:0]  pitch;
    logic [9:0]  step;
    logic [15:0] win_st;
    logic [15:0] win_wid;
    logic [7:0]  ldly;
    logic        clp_s1;
    logic        clp_s2;
    logic        clp_s3;
    logic [15:0] pix_cnt;
    logic [9:0]  hp_cnt;
    logic [9:0]  vl_cnt;
    logic        first_line;
    logic [9:0]  lat_lcnt;
    logic [9:0]  lat_pcnt;
    logic [9:0]  line_cnt;
    logic        started;
    logic [2:0]  col_on;
    logic [7:0]  dly_cnt;
    logic [9:0]  red;
    logic [9:0]  green;
    logic [9:0]  blue;
    logic        valid;
  } otpg_state_s;

  otpg_state_s st_r;
  otpg_state_s st_nxt;

  logic        clp_rise;
  logic        win_now;
  logic        h_clear;
  logic        h_tick;
  logic        v_clear;
  logic        v_tick;
  logic [9:0]  h_code;
  logic [9:0]  v_code;
  logic [9:0]  pat;
  logic [16:0] win_open;
  logic [16:0] win_close;
  logic [16:0] pix_ext;

  // ----------------------------------------------------------------
  // ramp channels
  // ----------------------------------------------------------------
  otpg_ramp u_hramp
  (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .clear_in (h_clear),
    .tick_in  (h_tick),
    .base_in  (st_r.base),
    .step_in  (st_r.step),
    .code_out (h_code)
  );

  otpg_ramp u_vramp
  (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .clear_in (v_clear),
    .tick_in  (v_tick),
    .base_in  (st_r.base),
    .step_in  (st_r.step),
    .code_out (v_code)
  );

  function automatic logic [9:0] otpg_colour(input logic [1:0] sel, input logic [1:0] me,
                                              input logic on, input logic [9:0] p, input logic [9:0] conv);
    if (!on)
      otpg_colour = conv;
    else if (sel == otpg_pkg::SEL_ALL || sel == me)
      otpg_colour = p;
    else
      otpg_colour = otpg_pkg::CODE_MAX;
  endfunction

  // ----------------------------------------------------------------
  // window and pitch timing
  // ----------------------------------------------------------------
  always_comb
  begin
    clp_rise  = st_r.clp_s2 && !st_r.clp_s3;
    win_open  = {1'b0, st_r.win_st} + 17'(otpg_pkg::START_OFFS);
    win_close = win_open + {1'b0, st_r.win_wid};
    pix_ext   = {1'b0, st_r.pix_cnt};
    win_now   = (pix_ext >= win_open) && (pix_ext < win_close) && !clp_rise;
    // horizontal ramp restarts each line, identical sequence every line
    h_clear   = !st_r.en || clp_rise;
    h_tick    = win_now && (st_r.hp_cnt == st_r.pitch - 10'h001);
    v_clear   = !st_r.en;
    // first pitch lines hold base, then one step per pitch lines
    v_tick    = clp_rise && !st_r.first_line && (st_r.vl_cnt == st_r.pitch - 10'h001);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    pat    = st_r.base;

    // bus slave: one wait cycle, answer on second edge
    case (st_r.bus)
      OTPG_BUS_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          st_nxt.bus   = OTPG_BUS_ACK;
          st_nxt.rdata = 32'h0000_0000;
          if (avs_write_in)
          begin
            if (avs_address_in == otpg_pkg::OFS_CTRL)
            begin
              if (avs_byteenable_in[0])
                st_nxt.en = avs_writedata_in[otpg_pkg::CTRL_EN_BIT];
              if (avs_byteenable_in[0])
                st_nxt.kind = avs_writedata_in[otpg_pkg::CTRL_KIND_LO +: 2];
              if (avs_byteenable_in[1])
                st_nxt.sel = avs_writedata_in[otpg_pkg::CTRL_SEL_LO +: 2];
            end
            else if (avs_address_in == otpg_pkg::OFS_BASE && avs_byteenable_in[1:0] == 2'h3)
              st_nxt.base = avs_writedata_in[9:0];
            else if (avs_address_in == otpg_pkg::OFS_PITCH && avs_byteenable_in[1:0] == 2'h3)
              // zero pitch would make the pitch counters wrap only at 1024; treat it as one
              st_nxt.pitch = (avs_writedata_in[9:0] == 10'h000) ? 10'h001 : avs_writedata_in[9:0];
            else if (avs_address_in == otpg_pkg::OFS_STEP && avs_byteenable_in[1:0] == 2'h3)
              st_nxt.step = avs_writedata_in[9:0];
            else if (avs_address_in == otpg_pkg::OFS_WIN_ST && avs_byteenable_in[1:0] == 2'h3)
              st_nxt.win_st = avs_writedata_in[15:0];
            else if (avs_address_in == otpg_pkg::OFS_WIN_WID && avs_byteenable_in[1:0] == 2'h3)
              st_nxt.win_wid = avs_writedata_in[15:0];
            else if (avs_address_in == otpg_pkg::OFS_LDLY && avs_byteenable_in[0])
              st_nxt.ldly = avs_writedata_in[7:0];
          end
          else
          begin
            if (avs_address_in == otpg_pkg::OFS_CTRL)
              st_nxt.rdata = {22'h0, st_r.sel, 2'h0, st_r.kind, 3'h0, st_r.en};
            else if (avs_address_in == otpg_pkg::OFS_BASE)
              st_nxt.rdata = {22'h0, st_r.base};
            else if (avs_address_in == otpg_pkg::OFS_PITCH)
              st_nxt.rdata = {22'h0, st_r.pitch};
            else if (avs_address_in == otpg_pkg::OFS_STEP)
              st_nxt.rdata = {22'h0, st_r.step};
            else if (avs_address_in == otpg_pkg::OFS_WIN_ST)
              st_nxt.rdata = {16'h0, st_r.win_st};
            else if (avs_address_in == otpg_pkg::OFS_WIN_WID)
              st_nxt.rdata = {16'h0, st_r.win_wid};
            else if (avs_address_in == otpg_pkg::OFS_LDLY)
              st_nxt.rdata = {24'h0, st_r.ldly};
            else if (avs_address_in == otpg_pkg::OFS_STATUS)
              st_nxt.rdata = {9'h0, st_r.col_on, st_r.started, 9'h0, st_r.line_cnt};
          end
        end
      end
      OTPG_BUS_ACK:
        st_nxt.bus = OTPG_BUS_IDLE;
      default:
        st_nxt.bus = OTPG_BUS_IDLE;
    endcase

    // clamp synchroniser
    st_nxt.clp_s1 = line_clamp_input_in;
    st_nxt.clp_s2 = st_r.clp_s1;
    st_nxt.clp_s3 = st_r.clp_s2;

    // pixel position counts from the clamp edge
    if (clp_rise)
      st_nxt.pix_cnt = 16'h0001;
    else if (st_r.pix_cnt != 16'hFFFF)
      st_nxt.pix_cnt = st_r.pix_cnt + 16'h0001;

    if (!st_r.en)
    begin
      // pattern state held at its start condition
      st_nxt.hp_cnt     = 10'h000;
      st_nxt.vl_cnt     = 10'h000;
      st_nxt.first_line = 1'b1;
      st_nxt.lat_lcnt   = 10'h000;
      st_nxt.lat_pcnt   = 10'h000;
      st_nxt.line_cnt   = 10'h000;
      st_nxt.started    = 1'b0;
      st_nxt.col_on     = 3'b000;
      st_nxt.dly_cnt    = 8'h00;
    end
    else
    begin
      if (clp_rise)
      begin
        st_nxt.hp_cnt   = 10'h000;
        st_nxt.lat_pcnt = 10'h000;
        st_nxt.line_cnt = st_r.line_cnt + 10'h001;
        if (st_r.first_line)
        begin
          st_nxt.first_line = 1'b0;
          st_nxt.vl_cnt     = 10'h000;
          st_nxt.lat_lcnt   = 10'h000;
        end
        else
        begin
          st_nxt.vl_cnt   = (st_r.vl_cnt == st_r.pitch - 10'h001) ? 10'h000 : st_r.vl_cnt + 10'h001;
          st_nxt.lat_lcnt = (st_r.lat_lcnt == st_r.pitch - 10'h001) ? 10'h000 : st_r.lat_lcnt + 10'h001;
        end
        // staggered colour start, only on the first start of a run
        if (!st_r.started)
        begin
          st_nxt.started = 1'b1;
          st_nxt.dly_cnt = 8'h00;
          st_nxt.col_on  = (st_r.ldly == 8'h00) ? 3'b111 : 3'b001;
        end
        else if (st_r.col_on != 3'b111)
        begin
          if (st_r.dly_cnt == st_r.ldly - 8'h01)
          begin
            st_nxt.dly_cnt = 8'h00;
            st_nxt.col_on  = {st_r.col_on[1:0], 1'b1};
          end
          else
            st_nxt.dly_cnt = st_r.dly_cnt + 8'h01;
        end
      end
      else if (win_now)
      begin
        st_nxt.hp_cnt   = (st_r.hp_cnt == st_r.pitch - 10'h001) ? 10'h000 : st_r.hp_cnt + 10'h001;
        st_nxt.lat_pcnt = (st_r.lat_pcnt == st_r.pitch - 10'h001) ? 10'h000 : st_r.lat_pcnt + 10'h001;
      end
    end

    // pattern select
    case (st_r.kind)
      otpg_pkg::KIND_FIXED: pat = st_r.base;
      otpg_pkg::KIND_HORIZ: pat = h_code;
      otpg_pkg::KIND_VERT:  pat = v_code;
      otpg_pkg::KIND_LATT:
        // full step line at the pitch line, else one step pixel per pitch pixels
        pat = (st_r.lat_lcnt == 10'h000 || st_r.lat_pcnt == 10'h000) ? st_r.step : st_r.base;
      default: pat = st_r.base;
    endcase

    // outputs: pattern only on started colours inside the window
    st_nxt.valid = win_now;
    st_nxt.red   = otpg_colour(st_r.sel, otpg_pkg::SEL_RED,   st_r.en && win_now && st_r.col_on[0],
                               pat, conv_red_in);
    st_nxt.green = otpg_colour(st_r.sel, otpg_pkg::SEL_GREEN, st_r.en && win_now && st_r.col_on[1],
                               pat, conv_green_in);
    st_nxt.blue  = otpg_colour(st_r.sel, otpg_pkg::SEL_BLUE,  st_r.en && win_now && st_r.col_on[2],
                               pat, conv_blue_in);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      st_r            <= '0;
      st_r.bus        <= OTPG_BUS_IDLE;
      st_r.base       <= otpg_pkg::BASE_RST;
      st_r.pitch      <= otpg_pkg::PITCH_RST;
      st_r.step       <= otpg_pkg::STEP_RST;
      st_r.win_st     <= otpg_pkg::WIN_ST_RST;
      st_r.win_wid    <= otpg_pkg::WIN_WID_RST;
      st_r.ldly       <= otpg_pkg::LDLY_RST;
      st_r.first_line <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    avs_readdata_out    = st_r.rdata;
    avs_waitrequest_out = (st_r.bus == OTPG_BUS_IDLE);
    pix_red_out         = st_r.red;
    pix_green_out       = st_r.green;
    pix_blue_out        = st_r.blue;
    pix_valid_out       = st_r.valid;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  win_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (clp_rise && st_r.win_wid != 16'h0 && st_r.win_st == 16'h0) |-> ##6 win_now)
    else $error("window did not open six pixels after clamp");
  win_stop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (win_now && !clp_rise && pix_ext == win_close - 17'h1) |=> !win_now)
    else $error("window outlasted width");
  sw_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.en && !avs_write_in) |=> st_r.en)
    else $error("enable dropped without a write");
  fix_lvl_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.en && win_now && st_r.kind == 2'h0 && st_r.sel == 2'h0 && st_r.col_on[0]) |=> pix_red_out == $past(st_r.base))
    else $error("fixed level wrong");
  unsel_max_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.en && win_now && st_r.sel == 2'h1 && st_r.col_on[1]) |=> pix_green_out == 10'h3FF)
    else $error("unselected colour not at max");
  pass_thru_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!st_r.en) |=> pix_blue_out == $past(conv_blue_in))
    else $error("converter data not passed");
  lat_line_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.en && win_now && st_r.kind == 2'h3 && st_r.sel == 2'h0 && st_r.col_on[0] && st_r.lat_lcnt == 10'h0)
    |=> pix_red_out == $past(st_r.step))
    else $error("lattice step line wrong");
  col_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!st_r.col_on[2] || st_r.col_on[1]) && (!st_r.col_on[1] || st_r.col_on[0]))
    else $error("colour start order broken");
  bus_ack_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.bus == OTPG_BUS_IDLE && (avs_read_in || avs_write_in)) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing wrong");
endmodule // otpg_top

// >>> verif/otpg_sink.sv
`timescale 1ns/1ns
// ----------------------------------------
// downstream consumer: measures each line's valid window
// ----------------------------------------
module otpg_sink
(
  input  wire logic        clk_in,
  input  wire logic        clamp_in,
  input  wire logic        valid_in,
  output logic      [15:0] count_out,
  output logic      [15:0] first_out
);
  logic        clamp_r;
  logic [15:0] ofs_r;

  // offset is counted from the edge that launched the clamp pin, so first_out is pin-relative
  always_ff @(posedge clk_in)
  begin
    clamp_r <= clamp_in;
    if (clamp_in && !clamp_r)
    begin
      ofs_r     <= 16'h0001;
      count_out <= 16'h0000;
    end
    else
    begin
      ofs_r <= ofs_r + 16'h0001;
      if (valid_in)
      begin
        count_out <= count_out + 16'h0001;
        if (count_out == 16'h0000)
        begin
          first_out <= ofs_r;
        end
      end
    end
  end
endmodule // otpg_sink

// >>> verif/otpg_top_tb.sv
`timescale 1ns/1ns
module otpg_top_tb;
  logic        clk_in;
  logic        rstn_in;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        clamp;
  logic [9:0]  conv [3];
  logic [9:0]  pix [3];
  logic        pix_valid;
  logic [15:0] sink_cnt;
  logic [15:0] sink_first;
  logic [31:0] rd;
  int          error_cnt;
  int          num_checks;
  int          cycles;
  int          en, kind, sel, base, pitch, step, ldly, wst, wwid;

  otpg_top dut
  (
    .clk_in              (clk_in),
    .rstn_in             (rstn_in),
    .avs_address_in      (avs_address),
    .avs_read_in         (avs_read),
    .avs_write_in        (avs_write),
    .avs_writedata_in    (avs_writedata),
    .avs_byteenable_in   (4'hF),
    .avs_readdata_out    (avs_readdata),
    .avs_waitrequest_out (avs_waitrequest),
    .line_clamp_input_in (clamp),
    .conv_red_in         (conv[0]),
    .conv_green_in       (conv[1]),
    .conv_blue_in        (conv[2]),
    .pix_red_out         (pix[0]),
    .pix_green_out       (pix[1]),
    .pix_blue_out        (pix[2]),
    .pix_valid_out       (pix_valid)
  );

  otpg_sink sink
  (
    .clk_in    (clk_in),
    .clamp_in  (clamp),
    .valid_in  (pix_valid),
    .count_out (sink_cnt),
    .first_out (sink_first)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_in);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  function automatic logic [9:0] ramp(input int n);
    int c;
    c = base;
    repeat (n) c = (c + step > 10'h3FF) ? base : c + step;
    return c[9:0];
  endfunction

  function automatic logic [9:0] col_exp(input int c, input int line, input int idx);
    logic [9:0] p;
    case (kind)
      0: p = base[9:0];
      1: p = ramp(idx / pitch);
      2: p = ramp(line / pitch);
      default: p = (line % pitch == 0 || idx % pitch == 0) ? step[9:0] : base[9:0];
    endcase
    if (en == 0 || line < c * ldly)
      return conv[c];
    return (sel == 0 || sel == c + 1) ? p : 10'h3FF;
  endfunction

  // clears the switch first so every setup starts from line 0
  task automatic cfg(input int k, s, b, p, st, ws, ww, ld);
    kind = k; sel = s; base = b; pitch = p; step = st; wst = ws; wwid = ww; ldly = ld;
    en = 1;
    bus_wr(otpg_pkg::OFS_CTRL, 32'h0);
    bus_wr(otpg_pkg::OFS_BASE, b);
    bus_wr(otpg_pkg::OFS_PITCH, p);
    bus_wr(otpg_pkg::OFS_STEP, st);
    bus_wr(otpg_pkg::OFS_WIN_ST, ws);
    bus_wr(otpg_pkg::OFS_WIN_WID, ww);
    bus_wr(otpg_pkg::OFS_LDLY, ld);
    bus_wr(otpg_pkg::OFS_CTRL, {22'h0, s[1:0], 2'h0, k[1:0], 3'h0, 1'b1});
  endtask

  // one clamp pulse, every output cycle after the pulse judged, then window placement and length
  task automatic run_line(input int line);
    int idx;
    idx = 0;
    @(posedge clk_in);
    clamp <= 1'b1;
    repeat (4) @(posedge clk_in);
    clamp <= 1'b0;
    repeat (wst + wwid + 14)
    begin
      @(posedge clk_in);
      for (int c = 0; c < 3; c++)
        chk(pix[c], pix_valid ? col_exp(c, line, idx) : conv[c]);
      if (pix_valid)
        idx++;
    end
    chk(sink_cnt, wwid);
    // two sync stages, edge stage and output register put the first valid pixel start+9 edges after launch
    chk(sink_first, wst + 9);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_reset();
    bus_rd(otpg_pkg::OFS_CTRL, rd);
    chk(rd, 32'h0);
    bus_rd(otpg_pkg::OFS_STEP, rd);
    chk(rd, 32'h1);
    bus_rd(6'h20, rd);
    chk(rd, 32'h0);
    bus_wr(otpg_pkg::OFS_PITCH, 32'h0);
    bus_rd(otpg_pkg::OFS_PITCH, rd);
    chk(rd, 32'h1);
    @(posedge clk_in);
    conv[0] <= 10'h2AA;
    @(posedge clk_in);
    chk(pix[0], 10'h011);
    @(posedge clk_in);
    chk(pix[0], 10'h2AA);
  endtask

  task automatic sc_fixed();
    cfg(0, 0, 'h155, 1, 1, 3, 20, 0);
    run_line(0);
    run_line(1);
  endtask

  task automatic sc_colsel();
    cfg(0, 1, 'h000, 1, 1, 0, 6, 0);
    run_line(0);
    cfg(0, 2, 'h155, 1, 1, 0, 6, 0);
    run_line(0);
    cfg(0, 3, 'h3FF, 1, 1, 0, 6, 0);
    run_line(0);
  endtask

  task automatic sc_horiz();
    cfg(1, 0, 'h3F0, 2, 8, 2, 12, 0);
    run_line(0);
    run_line(1);
  endtask

  task automatic sc_vert();
    cfg(2, 0, 'h3E8, 2, 10, 0, 6, 0);
    for (int l = 0; l < 8; l++)
      run_line(l);
  endtask

  task automatic sc_latt();
    cfg(3, 0, 'h040, 3, 'h300, 1, 10, 0);
    for (int l = 0; l < 5; l++)
      run_line(l);
  endtask

  task automatic sc_delay();
    cfg(0, 0, 'h100, 1, 1, 0, 8, 2);
    for (int l = 0; l < 6; l++)
      run_line(l);
    bus_rd(otpg_pkg::OFS_STATUS, rd);
    // status holds colours-on and started at [22:19], lines since enable at [9:0]
    chk(rd, 32'h0078_0006);
    bus_wr(otpg_pkg::OFS_CTRL, 32'h0);
    en = 0;
    run_line(0);
  endtask

  // ----------------------------------------
  // clock, reset, timeout, sequence
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    rstn_in       = 1'b0;
    avs_address   = 6'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    clamp         = 1'b0;
    conv[0]       = 10'h011;
    conv[1]       = 10'h022;
    conv[2]       = 10'h033;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    sc_reset();
    sc_fixed();
    sc_colsel();
    sc_horiz();
    sc_vert();
    sc_latt();
    sc_delay();
    summarize();
  end
endmodule // otpg_top_tb
